/* rtl/tx_channel_byte_store.sv */
`timescale 1ns/1ns
// Per-channel byte memory with registered read data
module tx_channel_byte_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // Clock
  input wire logic clk,
  // Write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read side
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Storage and read register; no reset, contents are live traffic
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

/* rtl/tx_path_config_bank.sv */
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
module tx_path_config_bank
  import txcfg_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int CHANNELS = 32
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // AXI4-Lite write address
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  // AXI4-Lite write data
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  // AXI4-Lite write response
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // AXI4-Lite read address
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  // AXI4-Lite read data
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // Framer mode from the same clock domain
  input wire logic T1_MODE,
  input wire logic ESF_FRAMING,
  // Transmit channel byte stream, same clock domain
  input wire logic CHAN_VALID,
  input wire logic [4:0] CHAN_NUM,
  input wire logic [7:0] CHAN_DATA,
  // System and line sync controls
  output logic SYS_CLOCK_RATE_SELECT,
  output logic SYS_SYNC_MULTIFRAME,
  output logic LINE_SYNC_OUTPUT_EN,
  output logic LINE_SYNC_MULTIFRAME,
  output logic SYNC_DOUBLE_WIDE,
  // Elastic store controls
  output logic CHANNEL_DATA_56K,
  output logic GAPPED_CLOCK_ENABLE,
  output logic [3:0] SLIP_THRESHOLD_BYTES,
  output logic ELASTIC_ALIGN_PULSE,
  output logic ELASTIC_RESET_PULSE,
  output logic ELASTIC_MIN_DELAY,
  output logic ELASTIC_STORE_ENABLE,
  // Alarm and loop code controls
  output logic REMOTE_ALARM_CI,
  output logic ALARM_INDICATION_CI,
  output logic [1:0] LOOP_CODE_LENGTH,
  output logic [4:0] LOOP_CODE_BASE_BITS,
  // HDLC watermark
  output logic [5:0] FIFO_LOW_WATERMARK,
  // Interleaved bus
  output logic INTERLEAVE_ACTIVE,
  output logic FRAME_INTERLEAVE,
  output logic [3:0] BUS_DEVICE_COUNT,
  output logic [2:0] BUS_DEVICE_POSITION,
  // Channel monitor and pattern port
  output logic [4:0] MONITOR_CHANNEL_SELECT,
  output logic PATTERN_TO_RECEIVE,
  output logic PATTERN_PORT_ENABLE
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] io;
    logic [7:0] es;
    logic [7:0] alm;
    logic [7:0] wm;
    logic [7:0] ib;
    logic [7:0] ms;
    logic [7:0] xp;
    logic aw_held;
    logic [9:0] aw_idx;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rate_sel;
    logic double_wide;
    logic [3:0] slip_bytes;
    logic align_pulse;
    logic reset_pulse;
    logic rai_ci;
    logic ais_ci;
    logic [4:0] loop_bits;
    logic [5:0] watermark;
    logic ib_active;
    logic [3:0] bus_count;
  } state_t;

  state_t st;
  state_t next_st;
  logic [7:0] mon_byte;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  // Shared by read and write paths so both agree on the map
  function automatic logic reg_known(input logic [9:0] idx);
    reg_known = (idx == IDX_IO) || (idx == IDX_ES) || (idx == IDX_ALM) ||
                (idx == IDX_WM) || (idx == IDX_IB) || (idx == IDX_MS) ||
                (idx == IDX_XP) || (idx == IDX_MON);
  endfunction

  function automatic logic [5:0] watermark_bytes(input logic [1:0] code);
    unique case (code)
      2'h0: watermark_bytes = WM_CODE0;
      2'h1: watermark_bytes = WM_CODE1;
      2'h2: watermark_bytes = WM_CODE2;
      2'h3: watermark_bytes = WM_CODE3;
    endcase
  endfunction

  function automatic logic [3:0] bus_devices(input logic [1:0] code);
    unique case (code)
      2'h0: bus_devices = BUS_CODE0;
      2'h1: bus_devices = BUS_CODE1;
      2'h2: bus_devices = BUS_CODE2;
      2'h3: bus_devices = BUS_RESERVED;
    endcase
  endfunction

  // Longest length of each code group; pattern engine divides down
  function automatic logic [4:0] loop_length(input logic [1:0] code);
    unique case (code)
      2'h0: loop_length = LOOP_CODE0;
      2'h1: loop_length = LOOP_CODE1;
      2'h2: loop_length = LOOP_CODE2;
      2'h3: loop_length = LOOP_CODE3;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Monitored channel bytes
  // ---------------------------------------------------------------
  // channel select
  tx_channel_byte_store #(
    .WIDTH(8),
    .DEPTH(CHANNELS),
    .AW(5)
  ) u_store (
    .clk(MCLK),
    .wr_en(CHAN_VALID),
    .wr_addr(CHAN_NUM),
    .wr_data(CHAN_DATA),
    .rd_addr(st.ms[4:0]),
    .rd_data(mon_byte)
  );

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.align_pulse = 1'b0;
    next_st.reset_pulse = 1'b0;

    // Address and data may arrive in either order
    if (AWVALID && st.awready)
    begin
      next_st.aw_held = 1'b1;
      next_st.aw_idx = AWADDR[11:2];
    end
    if (WVALID && st.wready)
    begin
      next_st.w_held = 1'b1;
      next_st.w_data = WDATA[7:0];
      next_st.w_lane0 = WSTRB[0];
    end
    if (st.bvalid && BREADY)
    begin
      next_st.bvalid = 1'b0;
    end

    // Commit once both halves are held and the response slot is free
    if (next_st.aw_held && next_st.w_held && !next_st.bvalid)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = reg_known(next_st.aw_idx) ? RESP_OKAY : RESP_DECERR;
      if (next_st.w_lane0)
      begin
        unique case (next_st.aw_idx)
          IDX_IO: next_st.io = next_st.w_data & MASK_IO;
          IDX_ES: next_st.es = next_st.w_data & MASK_ES;
          IDX_ALM: next_st.alm = next_st.w_data & MASK_ALM;
          IDX_WM: next_st.wm = next_st.w_data & MASK_WM;
          IDX_IB: next_st.ib = next_st.w_data & MASK_IB;
          IDX_MS: next_st.ms = next_st.w_data & MASK_MS;
          IDX_XP: next_st.xp = next_st.w_data & MASK_XP;
          default: next_st.io = st.io;
        endcase
      end
    end
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready = !next_st.w_held && !next_st.bvalid;

    // Read channel: one read in flight, data captured at acceptance
    if (st.rvalid && RREADY)
    begin
      next_st.rvalid = 1'b0;
    end
    if (ARVALID && st.arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = reg_known(ARADDR[11:2]) ? RESP_OKAY : RESP_DECERR;
      unique case (ARADDR[11:2])
        IDX_IO: next_st.rdata = {24'h000000, st.io};
        IDX_ES: next_st.rdata = {24'h000000, st.es};
        IDX_ALM: next_st.rdata = {24'h000000, st.alm};
        IDX_WM: next_st.rdata = {24'h000000, st.wm};
        IDX_IB: next_st.rdata = {24'h000000, st.ib};
        IDX_MS: next_st.rdata = {24'h000000, st.ms};
        IDX_XP: next_st.rdata = {24'h000000, st.xp};
        IDX_MON: next_st.rdata = {24'h000000, mon_byte};
        default: next_st.rdata = 32'h00000000;
      endcase
    end
    next_st.arready = !next_st.rvalid;

    // rate select forced on by interleaved bus
    next_st.rate_sel = next_st.io[IO_RATE] || next_st.ib[IB_EN];

    // double-wide only in T1 with output sync
    // gated also for misuse in multiframe or input mode
    next_st.double_wide = next_st.io[IO_DW] && T1_MODE &&
                          next_st.io[IO_DIR] && !next_st.io[IO_LINE_MF];

    next_st.slip_bytes = next_st.es[ES_ZONE] ? SLIP_NARROW : SLIP_WIDE;

    next_st.align_pulse = next_st.es[ES_ALIGN] && !st.es[ES_ALIGN];
    // pointer reset on rising edge only
    next_st.reset_pulse = next_st.es[ES_RESET] && !st.es[ES_RESET];

    // RAI CI pattern only in T1 extended superframe; AIS CI in any T1 framing
    next_st.rai_ci = next_st.alm[ALM_RAI] && T1_MODE && ESF_FRAMING;
    next_st.ais_ci = next_st.alm[ALM_AIS] && T1_MODE;

    next_st.loop_bits = loop_length(next_st.alm[1:0]);
    next_st.watermark = watermark_bytes(next_st.wm[1:0]);
    next_st.bus_count = bus_devices(next_st.ib[6:5]);
    next_st.ib_active = next_st.ib[IB_EN];

    if (RST)
    begin
      next_st = '0;
      next_st.io = RST_REG;
      next_st.es = RST_REG;
      next_st.alm = RST_REG;
      next_st.wm = RST_REG;
      next_st.ib = RST_REG;
      next_st.ms = RST_REG;
      next_st.xp = RST_REG;
      next_st.slip_bytes = SLIP_WIDE;
      next_st.loop_bits = LOOP_CODE0;
      next_st.watermark = WM_CODE0;
      next_st.bus_count = BUS_CODE0;
    end
  end

  // Single state register, synchronous reset folded in above
  always_ff @(posedge MCLK)
  begin
    st <= next_st;
  end

  // ---------------------------------------------------------------
  // Outputs, all straight from state flops
  // ---------------------------------------------------------------
  // Bus handshake
  assign AWREADY = st.awready;
  assign WREADY = st.wready;
  assign BVALID = st.bvalid;
  assign BRESP = st.bresp;
  assign ARREADY = st.arready;
  assign RVALID = st.rvalid;
  assign RDATA = st.rdata;
  assign RRESP = st.rresp;

  // Sync pin modes
  assign SYS_CLOCK_RATE_SELECT = st.rate_sel;
  assign SYS_SYNC_MULTIFRAME = st.io[IO_SYS_MF];
  assign LINE_SYNC_OUTPUT_EN = st.io[IO_DIR];
  assign LINE_SYNC_MULTIFRAME = st.io[IO_LINE_MF];
  assign SYNC_DOUBLE_WIDE = st.double_wide;

  // Elastic store
  // 56 or 64 kbps format
  assign CHANNEL_DATA_56K = st.es[ES_FMT];
  assign GAPPED_CLOCK_ENABLE = st.es[ES_GAP];
  assign SLIP_THRESHOLD_BYTES = st.slip_bytes;
  assign ELASTIC_ALIGN_PULSE = st.align_pulse;
  assign ELASTIC_RESET_PULSE = st.reset_pulse;
  assign ELASTIC_MIN_DELAY = st.es[ES_MIN];
  assign ELASTIC_STORE_ENABLE = st.es[ES_EN];

  // Alarms and loop code
  assign REMOTE_ALARM_CI = st.rai_ci;
  assign ALARM_INDICATION_CI = st.ais_ci;
  assign LOOP_CODE_LENGTH = st.alm[1:0];
  assign LOOP_CODE_BASE_BITS = st.loop_bits;
  assign FIFO_LOW_WATERMARK = st.watermark;

  // Interleaved bus
  assign INTERLEAVE_ACTIVE = st.ib_active;
  assign FRAME_INTERLEAVE = st.ib[IB_SEL];
  assign BUS_DEVICE_COUNT = st.bus_count;
  assign BUS_DEVICE_POSITION = st.ib[2:0];

  // Monitor and pattern port
  assign MONITOR_CHANNEL_SELECT = st.ms[4:0];
  assign PATTERN_TO_RECEIVE = st.xp[XP_DIR];
  assign PATTERN_PORT_ENABLE = st.xp[XP_EN];

endmodule

/* rtl/txcfg_pkg.sv */
package txcfg_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [9:0] IDX_IO = 10'h184;
  localparam logic [9:0] IDX_ES = 10'h185;
  localparam logic [9:0] IDX_ALM = 10'h186;
  localparam logic [9:0] IDX_WM = 10'h187;
  localparam logic [9:0] IDX_IB = 10'h188;
  localparam logic [9:0] IDX_MS = 10'h189;
  localparam logic [9:0] IDX_XP = 10'h18a;
  localparam logic [9:0] IDX_MON = 10'h1a0;

  // ---------------------------------------------------------------
  // Writable bit masks and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] MASK_IO = 8'hff;
  localparam logic [7:0] MASK_ES = 8'hdf;
  localparam logic [7:0] MASK_ALM = 8'h0f;
  localparam logic [7:0] MASK_WM = 8'h03;
  localparam logic [7:0] MASK_IB = 8'h7f;
  localparam logic [7:0] MASK_MS = 8'h1f;
  localparam logic [7:0] MASK_XP = 8'h07;
  localparam logic [7:0] RST_REG = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int IO_RATE = 4;
  localparam int IO_SYS_MF = 3;
  localparam int IO_DIR = 2;
  localparam int IO_DW = 1;
  localparam int IO_LINE_MF = 0;
  localparam int ES_FMT = 7;
  localparam int ES_GAP = 6;
  localparam int ES_ZONE = 4;
  localparam int ES_ALIGN = 3;
  localparam int ES_RESET = 2;
  localparam int ES_MIN = 1;
  localparam int ES_EN = 0;
  localparam int ALM_RAI = 3;
  localparam int ALM_AIS = 2;
  localparam int IB_SEL = 4;
  localparam int IB_EN = 3;
  localparam int XP_DIR = 2;
  localparam int XP_EN = 0;

  // ---------------------------------------------------------------
  // Decoded values
  // ---------------------------------------------------------------
  localparam logic [3:0] SLIP_WIDE = 4'h9;
  localparam logic [3:0] SLIP_NARROW = 4'h2;
  localparam logic [5:0] WM_CODE0 = 6'h04;
  localparam logic [5:0] WM_CODE1 = 6'h10;
  localparam logic [5:0] WM_CODE2 = 6'h20;
  localparam logic [5:0] WM_CODE3 = 6'h30;
  localparam logic [3:0] BUS_CODE0 = 4'h2;
  localparam logic [3:0] BUS_CODE1 = 4'h4;
  localparam logic [3:0] BUS_CODE2 = 4'h8;
  localparam logic [3:0] BUS_RESERVED = 4'h0;
  localparam logic [4:0] LOOP_CODE0 = 5'h05;
  localparam logic [4:0] LOOP_CODE1 = 5'h06;
  localparam logic [4:0] LOOP_CODE2 = 5'h07;
  localparam logic [4:0] LOOP_CODE3 = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

/* verification/tx_path_config_bank_bench.sv */
`timescale 1ns/1ns
module tx_path_config_bank_bench;
  import txcfg_pkg::*;
  // ----------------------------------------
  // Signals and tables
  // ----------------------------------------
  typedef struct packed {logic [9:0] idx; logic [7:0] wd; logic [7:0] rd; logic [15:0] out;} row_t;
  logic MCLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, T1_MODE, ESF_FRAMING, CHAN_VALID;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [11:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rdat;
  logic [3:0] WSTRB, SLIP_THRESHOLD_BYTES, BUS_DEVICE_COUNT;
  logic [1:0] BRESP, RRESP, LOOP_CODE_LENGTH, resp;
  logic [4:0] CHAN_NUM, LOOP_CODE_BASE_BITS, MONITOR_CHANNEL_SELECT;
  logic [7:0] CHAN_DATA;
  logic [5:0] FIFO_LOW_WATERMARK;
  logic [2:0] BUS_DEVICE_POSITION;
  logic SYS_CLOCK_RATE_SELECT, SYS_SYNC_MULTIFRAME, LINE_SYNC_OUTPUT_EN, LINE_SYNC_MULTIFRAME;
  logic SYNC_DOUBLE_WIDE, CHANNEL_DATA_56K, GAPPED_CLOCK_ENABLE, ELASTIC_ALIGN_PULSE;
  logic ELASTIC_RESET_PULSE, ELASTIC_MIN_DELAY, ELASTIC_STORE_ENABLE, REMOTE_ALARM_CI;
  logic ALARM_INDICATION_CI, INTERLEAVE_ACTIVE, FRAME_INTERLEAVE, PATTERN_TO_RECEIVE;
  logic PATTERN_PORT_ENABLE;
  int n_errors = 0;
  int n_checks = 0;
  int n_align = 0;
  int n_reset = 0;
  // Write value, readback, packed outputs expected
  row_t rows [21] = '{'{IDX_IO, 8'h16, 8'h16, 16'h016}, '{IDX_IO, 8'h0d, 8'h0d, 16'h00d},
    '{IDX_ES, 8'hff, 8'hdf, 16'h0cb}, '{IDX_ES, 8'h00, 8'h00, 16'h024},
    '{IDX_ALM, 8'hff, 8'h0f, 16'h1f0}, '{IDX_ALM, 8'h09, 8'h09, 16'h126},
    '{IDX_ALM, 8'h06, 8'h06, 16'h0c7}, '{IDX_ALM, 8'h00, 8'h00, 16'h005},
    '{IDX_WM, 8'h00, 8'h00, 16'h004}, '{IDX_WM, 8'h01, 8'h01, 16'h010},
    '{IDX_WM, 8'h02, 8'h02, 16'h020}, '{IDX_WM, 8'hff, 8'h03, 16'h030},
    '{IDX_IB, 8'hff, 8'h7f, 16'h187}, '{IDX_IB, 8'h25, 8'h25, 16'h025},
    '{IDX_IB, 8'h42, 8'h42, 16'h042}, '{IDX_IB, 8'h10, 8'h10, 16'h090},
    '{IDX_IB, 8'h08, 8'h08, 16'h110}, '{IDX_MS, 8'hff, 8'h1f, 16'h01f},
    '{IDX_XP, 8'hff, 8'h07, 16'h003}, '{IDX_XP, 8'h04, 8'h04, 16'h002},
    '{IDX_XP, 8'h01, 8'h01, 16'h001}};
  logic [9:0] ri [7] = '{IDX_IO, IDX_ES, IDX_ALM, IDX_WM, IDX_IB, IDX_MS, IDX_XP};
  logic [15:0] ro [7] = '{16'h0, 16'h024, 16'h005, 16'h004, 16'h010, 16'h0, 16'h0};

  tx_path_config_bank u_dut (.MCLK, .RST, .AWVALID, .AWREADY, .AWADDR, .AWPROT(3'h0),
    .WVALID, .WREADY, .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY,
    .ARADDR, .ARPROT(3'h0), .RVALID, .RREADY, .RDATA, .RRESP, .T1_MODE, .ESF_FRAMING,
    .CHAN_VALID, .CHAN_NUM, .CHAN_DATA, .SYS_CLOCK_RATE_SELECT, .SYS_SYNC_MULTIFRAME,
    .LINE_SYNC_OUTPUT_EN, .LINE_SYNC_MULTIFRAME, .SYNC_DOUBLE_WIDE, .CHANNEL_DATA_56K,
    .GAPPED_CLOCK_ENABLE, .SLIP_THRESHOLD_BYTES, .ELASTIC_ALIGN_PULSE, .ELASTIC_RESET_PULSE,
    .ELASTIC_MIN_DELAY, .ELASTIC_STORE_ENABLE, .REMOTE_ALARM_CI, .ALARM_INDICATION_CI,
    .LOOP_CODE_LENGTH, .LOOP_CODE_BASE_BITS, .FIFO_LOW_WATERMARK, .INTERLEAVE_ACTIVE,
    .FRAME_INTERLEAVE, .BUS_DEVICE_COUNT, .BUS_DEVICE_POSITION, .MONITOR_CHANNEL_SELECT,
    .PATTERN_TO_RECEIVE, .PATTERN_PORT_ENABLE);

  // 20 MHz clock
  initial
  begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end

  // Pulses are counted, since they only last one cycle
  always @(posedge MCLK)
  begin
    if (ELASTIC_ALIGN_PULSE === 1'b1) n_align++;
    if (ELASTIC_RESET_PULSE === 1'b1) n_reset++;
  end

  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  function automatic logic [15:0] outs(input logic [9:0] i);
    case (i)
      IDX_IO: return {11'h0, SYS_CLOCK_RATE_SELECT, SYS_SYNC_MULTIFRAME, LINE_SYNC_OUTPUT_EN,
        SYNC_DOUBLE_WIDE, LINE_SYNC_MULTIFRAME};
      IDX_ES: return {8'h0, CHANNEL_DATA_56K, GAPPED_CLOCK_ENABLE, SLIP_THRESHOLD_BYTES,
        ELASTIC_MIN_DELAY, ELASTIC_STORE_ENABLE};
      IDX_ALM: return {7'h0, REMOTE_ALARM_CI, ALARM_INDICATION_CI, LOOP_CODE_LENGTH,
        LOOP_CODE_BASE_BITS};
      IDX_WM: return {10'h0, FIFO_LOW_WATERMARK};
      IDX_IB: return {7'h0, INTERLEAVE_ACTIVE, FRAME_INTERLEAVE, BUS_DEVICE_COUNT,
        BUS_DEVICE_POSITION};
      IDX_MS: return {11'h0, MONITOR_CHANNEL_SELECT};
      default: return {14'h0, PATTERN_TO_RECEIVE, PATTERN_PORT_ENABLE};
    endcase
  endfunction

  // Mode gated outputs: remote alarm CI, alarm indication CI, double wide
  function automatic logic [31:0] gated();
    return {29'h0, REMOTE_ALARM_CI, ALARM_INDICATION_CI, SYNC_DOUBLE_WIDE};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic s);
    @(posedge MCLK);
    AWADDR <= {i, 2'b00};
    WDATA <= {24'h0, d};
    WSTRB <= {3'h0, s};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do
    begin
      @(posedge MCLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end
    while (BVALID !== 1'b1);
    resp = BRESP;
    BREADY <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [9:0] i);
    @(posedge MCLK);
    ARADDR <= {i, 2'b00};
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do
    begin
      @(posedge MCLK);
      if (ARREADY) ARVALID <= 1'b0;
    end
    while (RVALID !== 1'b1);
    rdat = RDATA;
    resp = RRESP;
    RREADY <= 1'b0;
    #1;
  endtask

  task automatic end_sim();
    $display("Checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Hang guard, far beyond the 66 accesses made
  initial
  begin
    repeat (5000) @(posedge MCLK);
    n_errors++;
    end_sim();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, CHAN_VALID} = 7'h40;
    {AWADDR, ARADDR, WDATA, WSTRB, CHAN_NUM, CHAN_DATA} = '0;
    T1_MODE = 1'b1;
    ESF_FRAMING = 1'b1;
    repeat (12) @(posedge MCLK);
    RST <= 1'b0;
    foreach (rows[k])
    begin
      wr(rows[k].idx, rows[k].wd, 1'b1);
      chk("write resp", {30'h0, RESP_OKAY}, {30'h0, resp});
      chk("outputs", {16'h0, rows[k].out}, {16'h0, outs(rows[k].idx)});
      rd(rows[k].idx);
      chk("readback", {24'h0, rows[k].rd}, rdat);
    end
    // Interleave enable still set from the table
    wr(IDX_IO, 8'h00, 1'b1);
    chk("rate forced", 32'h1, {31'h0, SYS_CLOCK_RATE_SELECT});
    wr(IDX_IB, 8'h00, 1'b1);
    chk("rate clear", 32'h0, {31'h0, SYS_CLOCK_RATE_SELECT});
    // Edges only: 1 over 1 gives nothing
    wr(IDX_ES, 8'h08, 1'b1);
    wr(IDX_ES, 8'h08, 1'b1);
    wr(IDX_ES, 8'h04, 1'b1);
    wr(IDX_ES, 8'h0c, 1'b1);
    wr(IDX_ES, 8'h00, 1'b1); // reset bit not left high
    chk("align pulses", 32'd3, n_align);
    chk("reset pulses", 32'd2, n_reset);
    // Mode gated alarm and sync outputs; double wide only in T1 mode
    wr(IDX_IO, 8'h16, 1'b1);
    wr(IDX_ALM, 8'h0c, 1'b1);
    chk("gated t1 esf", 32'h7, gated());
    @(posedge MCLK);
    ESF_FRAMING <= 1'b0;
    repeat (2) @(posedge MCLK);
    chk("gated t1", 32'h3, gated());
    T1_MODE <= 1'b0;
    repeat (2) @(posedge MCLK);
    chk("gated e1", 32'h0, gated());
    T1_MODE <= 1'b1;
    ESF_FRAMING <= 1'b1;
    // Strobe off leaves the register alone
    wr(IDX_ALM, 8'h00, 1'b0);
    rd(IDX_ALM);
    chk("no strobe", 32'h0c, rdat);
    // Unmapped place
    wr(10'h18b, 8'hff, 1'b1);
    chk("unmapped wr", {30'h0, RESP_DECERR}, {30'h0, resp});
    rd(10'h18b);
    chk("unmapped rd", {30'h0, RESP_DECERR}, {30'h0, resp});
    chk("unmapped data", 32'h0, rdat);
    // Last and first channel into the monitor
    @(posedge MCLK);
    CHAN_VALID <= 1'b1;
    CHAN_NUM <= 5'h1f;
    CHAN_DATA <= 8'ha5;
    @(posedge MCLK);
    CHAN_NUM <= 5'h00;
    CHAN_DATA <= 8'h3c;
    @(posedge MCLK);
    CHAN_VALID <= 1'b0;
    wr(IDX_MS, 8'h1f, 1'b1);
    rd(IDX_MON);
    chk("monitor ch32", 32'ha5, rdat);
    wr(IDX_MS, 8'h00, 1'b1);
    rd(IDX_MON);
    chk("monitor ch1", 32'h3c, rdat);
    // Reset in mid-run restores every register
    @(posedge MCLK);
    RST <= 1'b1;
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    foreach (ri[k])
    begin
      chk("reset outputs", {16'h0, ro[k]}, {16'h0, outs(ri[k])});
      rd(ri[k]);
      chk("reset value", 32'h0, rdat);
    end
    end_sim();
  end
endmodule

/* verification/tx_path_config_bank_sva.sv */
`timescale 1ns/1ns
module tx_path_config_bank_sva (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Register bus
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic [1:0] BRESP,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic [31:0] RDATA,
  // Mode and config outputs
  input wire logic T1_MODE,
  input wire logic SYS_CLOCK_RATE_SELECT,
  input wire logic INTERLEAVE_ACTIVE,
  input wire logic LINE_SYNC_OUTPUT_EN,
  input wire logic LINE_SYNC_MULTIFRAME,
  input wire logic SYNC_DOUBLE_WIDE,
  input wire logic [3:0] SLIP_THRESHOLD_BYTES,
  input wire logic ELASTIC_ALIGN_PULSE,
  input wire logic ELASTIC_RESET_PULSE,
  input wire logic [5:0] FIFO_LOW_WATERMARK,
  input wire logic [3:0] BUS_DEVICE_COUNT
);
  // ----------------------------------------
  // Properties, all in the one clock domain
  // ----------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  rate_force_a: assert property (INTERLEAVE_ACTIVE |-> SYS_CLOCK_RATE_SELECT)
    else $error("rate select low while interleave active");
  double_wide_a: assert property (SYNC_DOUBLE_WIDE |-> LINE_SYNC_OUTPUT_EN &&
    !LINE_SYNC_MULTIFRAME && $past(T1_MODE)) else $error("double wide outside T1 output");
  slip_value_a: assert property (SLIP_THRESHOLD_BYTES == 4'h9 ||
    SLIP_THRESHOLD_BYTES == 4'h2) else $error("slip threshold not 9 or 2");
  align_pulse_a: assert property (ELASTIC_ALIGN_PULSE |-> $rose(BVALID)
    ##1 !ELASTIC_ALIGN_PULSE) else $error("align pulse not one cycle at write");
  reset_pulse_a: assert property ($rose(ELASTIC_RESET_PULSE) |-> BVALID
    ##1 $fell(ELASTIC_RESET_PULSE)) else $error("reset pulse not one cycle at write");
  mark_value_a: assert property (FIFO_LOW_WATERMARK inside {6'h04, 6'h10, 6'h20, 6'h30})
    else $error("watermark value illegal");
  bus_count_a: assert property (BUS_DEVICE_COUNT inside {4'h0, 4'h2, 4'h4, 4'h8})
    else $error("bus device count illegal");
  upper_zero_a: assert property (RVALID |-> RDATA[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  // Write answered next cycle
  write_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY |=> BVALID)
    else $error("no write response after both halves taken");
  // Read answered next cycle
  read_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("no read data after address taken");

  cover property (ELASTIC_ALIGN_PULSE);
  cover property (BVALID && BRESP == 2'h3);
  cover property (SYNC_DOUBLE_WIDE);
endmodule

bind tx_path_config_bank tx_path_config_bank_sva u_sva (
  .MCLK, .RST, .AWVALID, .AWREADY, .WVALID, .WREADY, .BVALID, .BRESP, .ARVALID,
  .ARREADY, .RVALID, .RDATA, .T1_MODE, .SYS_CLOCK_RATE_SELECT, .INTERLEAVE_ACTIVE,
  .LINE_SYNC_OUTPUT_EN, .LINE_SYNC_MULTIFRAME, .SYNC_DOUBLE_WIDE, .SLIP_THRESHOLD_BYTES,
  .ELASTIC_ALIGN_PULSE, .ELASTIC_RESET_PULSE, .FIFO_LOW_WATERMARK, .BUS_DEVICE_COUNT
);
